// File: logic/swba_alu.sv
// Subtract-with-borrow datapath: register and immediate forms, flags, accumulator
// Function
// [RULE_01] Register form: register plus inverted accumulator plus carry
// [RULE_02] Destination 0 writes accumulator, register untouched
// [RULE_03] Destination 1 writes result back to register
// [RULE_04] Six-bit register address, one-bit destination select
// [RULE_05] No borrow sets carry; zero result sets zero
// [RULE_06] Borrow clears carry, keeps wrapped result
// [RULE_07] Immediate form: literal minus accumulator, into accumulator
// [RULE_08] Each form completes within one instruction cycle
`timescale 1ns/1ps
module swba_alu
  import swba_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_op_valid,
  input wire logic i_op_form,
  input wire logic [SWBA_ADDR_W-1:0] i_reg_addr,
  input wire logic i_dest,
  input wire logic [SWBA_DATA_W-1:0] i_imm,
  input wire logic i_carry_in,
  input wire logic i_acc_wr,
  input wire logic [SWBA_DATA_W-1:0] i_acc_wdata,
  input wire logic i_rf_wr,
  input wire logic [SWBA_ADDR_W-1:0] i_rf_waddr,
  input wire logic [SWBA_DATA_W-1:0] i_rf_wdata,
  input wire logic [SWBA_ADDR_W-1:0] i_rf_raddr,
  output logic o_ready,
  output logic o_done,
  output logic [SWBA_DATA_W-1:0] o_result,
  output logic [SWBA_DATA_W-1:0] o_acc,
  output logic o_carry,
  output logic o_zero,
  output logic o_half_carry,
  output logic [SWBA_DATA_W-1:0] o_rf_rdata
);
  swba_rf_if rf ();

  swba_regfile u_regfile (
    .i_core_clk (i_core_clk),
    .i_rst_n (i_rst_n),
    .i_ce (i_ce),
    .rf (rf.mem)
  );

  swba_state_t state;
  swba_state_t next_state;
  logic op_form;
  logic op_dest;
  logic [SWBA_ADDR_W-1:0] op_addr;
  logic [SWBA_DATA_W-1:0] op_imm;
  logic op_c;
  logic [SWBA_DATA_W-1:0] acc;
  logic carry;
  logic zero;
  logic half_carry;
  logic done;
  logic [SWBA_DATA_W-1:0] result;
  logic next_op_form;
  logic next_op_dest;
  logic [SWBA_ADDR_W-1:0] next_op_addr;
  logic [SWBA_DATA_W-1:0] next_op_imm;
  logic next_op_c;
  logic [SWBA_DATA_W-1:0] next_acc;
  logic next_carry;
  logic next_zero;
  logic next_half_carry;
  logic next_done;
  logic [SWBA_DATA_W-1:0] next_result;
  logic [SWBA_DATA_W-1:0] operand;
  logic [SWBA_DATA_W:0] sum9;
  logic [SWBA_NIB_W:0] sum5;
  logic [SWBA_DATA_W-1:0] res8;

  // Minuend comes from memory or literal; subtrahend is the accumulator, added inverted
  always_comb begin
    operand = (op_form == SWBA_FORM_IMM) ? op_imm : rf.rdata; // RULE_07
    sum9 = {1'b0, operand} + {1'b0, ~acc} + {{SWBA_DATA_W{1'b0}}, op_c}; // RULE_01
    sum5 = {1'b0, operand[SWBA_NIB_W-1:0]} + {1'b0, ~acc[SWBA_NIB_W-1:0]} + {{SWBA_NIB_W{1'b0}}, op_c};
    res8 = sum9[SWBA_DATA_W-1:0]; // RULE_06
  end

  always_comb begin
    next_state = state;
    next_op_form = op_form;
    next_op_dest = op_dest;
    next_op_addr = op_addr;
    next_op_imm = op_imm;
    next_op_c = op_c;
    next_acc = acc;
    next_carry = carry;
    next_zero = zero;
    next_half_carry = half_carry;
    next_done = 1'b0;
    next_result = result;
    rf.we = 1'b0;
    rf.waddr = i_rf_waddr;
    rf.wdata = i_rf_wdata;
    rf.raddr = i_rf_raddr;
    case (state)
      SWBA_IDLE: begin
        if (i_op_valid) begin
          next_state = SWBA_EXEC;
          next_op_form = i_op_form;
          next_op_dest = i_dest; // RULE_04
          next_op_addr = i_reg_addr; // RULE_04
          next_op_imm = i_imm;
          next_op_c = i_carry_in;
          if (i_op_form == SWBA_FORM_REG) begin
            rf.raddr = i_reg_addr;
          end
        end else if (i_acc_wr) begin
          next_acc = i_acc_wdata;
        end
        if (!i_op_valid && i_rf_wr) begin
          rf.we = 1'b1;
        end
      end
      SWBA_EXEC: begin
        next_state = SWBA_IDLE; // RULE_08
        next_done = 1'b1;
        next_result = res8;
        next_carry = sum9[SWBA_DATA_W]; // RULE_05 RULE_06
        next_zero = (res8 == SWBA_ZERO_BYTE); // RULE_05
        next_half_carry = sum5[SWBA_NIB_W];
        rf.raddr = op_addr;
        if (op_form == SWBA_FORM_IMM || op_dest == SWBA_DEST_ACC) begin
          next_acc = res8; // RULE_02 RULE_07
        end else begin
          rf.we = 1'b1; // RULE_03
          rf.waddr = op_addr;
          rf.wdata = res8;
        end
      end
      default: begin
        next_state = SWBA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SWBA_IDLE;
      op_form <= SWBA_FORM_REG;
      op_dest <= SWBA_DEST_ACC;
      op_addr <= '0;
      op_imm <= SWBA_ZERO_BYTE;
      op_c <= 1'b0;
      acc <= SWBA_ACC_RST;
      carry <= 1'b0;
      zero <= 1'b0;
      half_carry <= 1'b0;
      done <= 1'b0;
      result <= SWBA_ZERO_BYTE;
    end else if (i_ce) begin
      state <= next_state;
      op_form <= next_op_form;
      op_dest <= next_op_dest;
      op_addr <= next_op_addr;
      op_imm <= next_op_imm;
      op_c <= next_op_c;
      acc <= next_acc;
      carry <= next_carry;
      zero <= next_zero;
      half_carry <= next_half_carry;
      done <= next_done;
      result <= next_result;
    end
  end

  assign o_ready = (state == SWBA_IDLE);
  assign o_done = done;
  assign o_result = result;
  assign o_acc = acc;
  assign o_carry = carry;
  assign o_zero = zero;
  assign o_half_carry = half_carry;
  assign o_rf_rdata = rf.rdata;

  sequence s_issue;
    o_ready && i_op_valid && i_ce;
  endsequence
  sequence s_exec;
    !o_ready && i_ce;
  endsequence

  a_exec_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_08
    s_issue ##1 s_exec |=> o_done && o_ready) else $error("operation did not finish in one instruction cycle");
  a_sum_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_01
    s_exec |=> o_result == 8'($past(operand) + ~$past(acc) + {7'h00, $past(op_c)})) else $error("wrong difference");
  a_acc_dest: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_02
    (s_exec and (op_form == SWBA_FORM_REG && op_dest == SWBA_DEST_ACC)) |=> o_acc == o_result)
    else $error("accumulator not written for destination 0");
  a_reg_dest: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_03
    (s_exec and (op_form == SWBA_FORM_REG && op_dest == SWBA_DEST_REG))
    |-> rf.we && rf.waddr == op_addr ##1 $stable(o_acc))
    else $error("register write-back missing or accumulator disturbed");
  a_zero_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_05
    o_done |-> o_zero == (o_result == 8'h00)) else $error("zero flag mismatch");
  a_no_borrow: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_05
    (s_exec and ({1'b0, operand} >= {1'b0, acc} + {8'h00, !op_c})) |=> o_carry)
    else $error("carry not set without borrow");
  a_borrow_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_06
    (s_exec and ({1'b0, operand} < {1'b0, acc} + {8'h00, ~op_c})) |=> !o_carry)
    else $error("carry not cleared on borrow");
  a_imm_to_acc: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_07
    (s_exec and (op_form == SWBA_FORM_IMM)) |-> !rf.we ##1 o_acc == o_result)
    else $error("immediate result not in accumulator");
  a_addr_width: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // RULE_04
    (s_issue and (i_op_form == SWBA_FORM_REG)) |-> rf.raddr == i_reg_addr)
    else $error("register address not presented");
endmodule

// File: logic/swba_pkg.sv
// Shared widths, reset values and encodings for the subtract-with-borrow slice
package swba_pkg;
  localparam int SWBA_DATA_W = 8;
  localparam int SWBA_ADDR_W = 6;
  localparam int SWBA_DEPTH = 64;
  localparam int SWBA_NIB_W = 4;
  localparam logic [SWBA_DATA_W-1:0] SWBA_ACC_RST = 8'h00;
  localparam logic [SWBA_DATA_W-1:0] SWBA_ZERO_BYTE = 8'h00;
  localparam logic SWBA_DEST_ACC = 1'b0;
  localparam logic SWBA_DEST_REG = 1'b1;
  localparam logic SWBA_FORM_REG = 1'b0;
  localparam logic SWBA_FORM_IMM = 1'b1;
  typedef enum logic {SWBA_IDLE, SWBA_EXEC} swba_state_t;
endpackage

// File: logic/swba_regfile.sv
// 64-byte data memory with registered read data
`timescale 1ns/1ps
module swba_regfile
  import swba_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  swba_rf_if.mem rf
);
  logic [SWBA_DATA_W-1:0] mem [SWBA_DEPTH];
  logic [SWBA_DATA_W-1:0] rdata;
  logic [SWBA_DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = i_ce ? mem[rf.raddr] : rdata;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= SWBA_ZERO_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_ce && rf.we) begin
      mem[rf.waddr] <= rf.wdata;
    end
  end

  assign rf.rdata = rdata;
endmodule

// File: logic/swba_rf_if.sv
// Register-file port between the datapath and its data memory
`timescale 1ns/1ps
interface swba_rf_if;
  import swba_pkg::*;
  logic we;
  logic [SWBA_ADDR_W-1:0] waddr;
  logic [SWBA_DATA_W-1:0] wdata;
  logic [SWBA_ADDR_W-1:0] raddr;
  logic [SWBA_DATA_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: sim/test_subtract_with_borrow_alu.sv
// Self-checking bench for the subtract-with-borrow datapath
`timescale 1ns/1ps
module test_subtract_with_borrow_alu;
  import swba_pkg::*;
  logic clk = 0, rst_n = 0, valid = 0, form = 0, dest = 0, cin = 0, awr = 0, rwr = 0, ce = 1;
  logic [SWBA_ADDR_W-1:0] addr = '0, waddr = '0, raddr = '0;
  logic [SWBA_DATA_W-1:0] imm = '0, awd = '0, rwd = '0, acc_m = '0;
  logic [SWBA_DATA_W-1:0] mem_m [SWBA_DEPTH];
  logic ready, done, carry, zero, half;
  logic [SWBA_DATA_W-1:0] res, acc, rdata;
  logic [18:0] exq [$];
  int n_fail = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  swba_alu DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_op_valid(valid), .i_op_form(form),
    .i_reg_addr(addr), .i_dest(dest), .i_imm(imm), .i_carry_in(cin), .i_acc_wr(awr), .i_acc_wdata(awd),
    .i_rf_wr(rwr), .i_rf_waddr(waddr), .i_rf_wdata(rwd), .i_rf_raddr(raddr), .o_ready(ready),
    .o_done(done), .o_result(res), .o_acc(acc), .o_carry(carry), .o_zero(zero),
    .o_half_carry(half), .o_rf_rdata(rdata));

  task automatic chk_res(input string nm, input logic [18:0] e, input logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_hs(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_mem(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (exq.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Result checker: each done pulse consumes the oldest expectation
  always @(negedge clk) begin
    if (rst_n && done === 1'b1) begin
      if (exq.size() == 0) chk_res("unexpected done", 19'h0, 19'h7FFFF);
      else chk_res("result", exq.pop_front(), {res, carry, zero, half, acc});
    end
  end

  // Accumulator load or memory write while idle
  task automatic wr(input logic to_acc, input logic [5:0] a, input logic [7:0] v);
    awr = to_acc;
    rwr = !to_acc;
    awd = v;
    rwd = v;
    waddr = a;
    if (to_acc) acc_m = v;
    else mem_m[a] = v;
    @(negedge clk);
  endtask

  // Strobes stay up after wr; the next task sets them in the same time step
  // Clock enable low: a held accumulator load and memory write must not land
  task automatic stall();
    ce = 0;
    awr = 1;
    rwr = 1;
    awd = 8'($urandom());
    rwd = ~awd;
    waddr = 6'($urandom());
    repeat (2) @(negedge clk);
    chk_hs("frozen", 2'b10, {ready, done});
    ce = 1;
  endtask

  // Issue one operation; junk adds core writes that must be refused
  task automatic op(input logic f, input logic [5:0] a, input logic d, input logic [7:0] i, input logic c,
                    input logic junk);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] x;
    x = f ? i : mem_m[a];
    s = x + {1'b0, ~acc_m} + c;
    h = x[3:0] + {1'b0, ~acc_m[3:0]} + c;
    if (f || !d) acc_m = s[7:0];
    else mem_m[a] = s[7:0];
    exq.push_back({s[7:0], s[8], s[7:0] == 8'h00, h[4], acc_m});
    chk_hs("ready", 2'b01, {1'b0, ready});
    valid = 1;
    form = f;
    addr = a;
    dest = d;
    imm = i;
    cin = c;
    awr = junk;
    rwr = junk;
    awd = ~s[7:0];
    rwd = ~s[7:0];
    waddr = a;
    @(negedge clk);
    valid = 0;
    awr = 0;
    rwr = 0;
    chk_hs("busy", 2'b00, {ready, done});
    @(negedge clk);
    chk_hs("done", 2'b11, {ready, done});
  endtask

  task automatic rd(input logic [5:0] a);
    awr = 0;
    rwr = 0;
    raddr = a;
    @(negedge clk);
    chk_mem("memory", mem_m[a], rdata);
  endtask

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h3E9D));
    repeat (10) @(negedge clk);
    rst_n = 1;
    for (int k = 0; k < SWBA_DEPTH; k++) wr(1'b0, k[5:0], 8'($urandom()));
    // Borrow, no-borrow and zero cases of both forms
    for (int k = 0; k < 8; k++) begin
      wr(1'b1, 6'h00, k[1] ? 8'h05 : 8'h06);
      wr(1'b0, 6'h3F, k[1] ? 8'h06 : 8'h05);
      op(k[2], 6'h3F, 1'b1, k[1] ? 8'h06 : 8'h05, k[0], k[0]);
      rd(6'h3F);
    end
    op(1'b0, 6'h00, 1'b0, 8'h00, 1'b1, 1'b1);
    for (int k = 0; k < 200; k++) begin
      op(1'($urandom()), 6'($urandom()), 1'($urandom()), 8'($urandom()), 1'($urandom()), 1'($urandom()));
      if (k % 4 == 0) wr(1'b1, 6'h00, 8'($urandom()));
      if (k % 8 == 0) stall();
    end
    for (int k = 0; k < SWBA_DEPTH; k++) rd(k[5:0]);
    report_and_stop();
  end
endmodule
